// file: rtl/vic_arb.sv
`timescale 1ns/1ns
module vic_arb (
  input wire logic clk_i,
  input wire logic srst_i,
  vic_arb_if.arb arb
);
  import vic_pkg::*;

  // ==========================================================
  // Priority search, ascending index so ties keep the lowest number
  always_comb begin
    arb.win_vld = 1'b0;
    arb.win_idx = '0;
    arb.win_prio = '1;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (arb.cand[i] && (!arb.win_vld || arb.prio[i] < arb.win_prio)) begin
        arb.win_vld = 1'b1;
        arb.win_idx = IDX_W'(i);
        arb.win_prio = arb.prio[i];
      end
    end
  end

  // ==========================================================
  // Checks
  logic better_seen;
  logic tie_lower;
  always_comb begin
    better_seen = 1'b0;
    tie_lower = 1'b0;
    for (int j = 0; j < NUM_SRC; j++) begin
      if (arb.cand[j] && arb.prio[j] < arb.win_prio) begin
        better_seen = 1'b1;
      end
      if (arb.cand[j] && arb.prio[j] == arb.win_prio && IDX_W'(j) < arb.win_idx) begin
        tie_lower = 1'b1;
      end
    end
  end

  win_any_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (|arb.cand) == arb.win_vld) else $error("winner valid does not follow candidates");
  win_urgent_a: assert property (@(posedge clk_i) disable iff (srst_i)
    arb.win_vld |-> (arb.cand[arb.win_idx] && !better_seen))
    else $error("winner is not the most urgent candidate");
  win_tie_a: assert property (@(posedge clk_i) disable iff (srst_i)
    arb.win_vld |-> !tie_lower) else $error("tie not resolved to lowest number");

endmodule

// file: rtl/vic_arb_if.sv
`timescale 1ns/1ns
interface vic_arb_if;
  import vic_pkg::*;
  logic [NUM_SRC-1:0] cand;
  logic [IMPL_W-1:0] prio [NUM_SRC];
  logic win_vld;
  logic [IDX_W-1:0] win_idx;
  logic [IMPL_W-1:0] win_prio;
  modport arb (input cand, input prio, output win_vld, output win_idx, output win_prio);
  modport ctl (output cand, output prio, input win_vld, input win_idx, input win_prio);
endinterface

// file: rtl/vic_pkg.sv
package vic_pkg;

  // ==========================================================
  // Sizes
  localparam int NUM_SRC = 32;
  localparam int IDX_W = 5;
  localparam int PRIO_W = 8;
  localparam int IMPL_W = 3;
  localparam int DEPTH_MAX = 8;
  localparam int DEPTH_W = 4;
  localparam int ADDR_W = 10;

  // ==========================================================
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_ENABLE = 10'h000;
  localparam logic [ADDR_W-1:0] OFF_EN_SET = 10'h004;
  localparam logic [ADDR_W-1:0] OFF_EN_CLR = 10'h008;
  localparam logic [ADDR_W-1:0] OFF_GMASK = 10'h00C;
  localparam logic [ADDR_W-1:0] OFF_GROUP = 10'h010;
  localparam logic [ADDR_W-1:0] OFF_PEND = 10'h014;
  localparam logic [ADDR_W-1:0] OFF_ACTIVE = 10'h018;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 10'h01C;
  localparam logic [ADDR_W-1:0] OFF_VBASE = 10'h020;
  localparam logic [2:0] PRIO_PAGE = 3'h1;

  // ==========================================================
  // Field positions
  localparam int GMASK_BIT = 0;
  localparam int STAT_INIRQ_BIT = 0;
  localparam int STAT_PRIO_LSB = 4;
  localparam int STAT_DEPTH_LSB = 8;
  localparam int STAT_NUM_LSB = 16;

  // ==========================================================
  // Reset values
  localparam logic [NUM_SRC-1:0] RST_ENABLE = 32'h0000_0000;
  localparam logic RST_GMASK = 1'b0;
  localparam logic [2:0] RST_GROUP = 3'h7;
  localparam logic [31:0] RST_VBASE = 32'h0000_0000;
  localparam logic [PRIO_W-1:0] RST_PRIO = 8'h00;
  localparam logic [2:0] GROUP_MAX = 3'h3;

  typedef enum logic {BUS_IDLE, BUS_DONE} vic_bus_st_t;

endpackage

// file: rtl/vic_top.sv
`timescale 1ns/1ns
// Contract
// - Thirty-two source inputs resolved over eight hardware priority levels.
// - Per-source masks plus a global mask that leaves them untouched.
// - On acceptance the core gets the winner's handler address directly.
// - Strictly higher preemption priority interrupts a running lower handler.
// - Software grouping splits priority bits into preemption and subpriority.
// - Equal preemption, different subpriority: no preemption, tail chain instead.
// - Ties in priority go to the lowest interrupt number.
// - Track nesting; leave interrupt context only when all is served.
// - Smaller priority value is more urgent; zero is highest.
// - Only the upper three priority bits take part in arbitration.
// - Grouping settings three through seven behave identically.
// - Grouping read-back returns the preemption bit count.
// - Per-source enable, set or cleared singly; disabled sources not forwarded.
// - Controller enables never touch peripheral-side enables or masks.
module vic_top (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [vic_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [vic_pkg::NUM_SRC-1:0] irq_src_i,
  input wire logic irq_ack_i,
  input wire logic irq_eoi_i,
  output logic irq_req_o,
  output logic [vic_pkg::IDX_W-1:0] irq_num_o,
  output logic [31:0] irq_addr_o,
  output logic in_irq_o,
  output logic [vic_pkg::DEPTH_W-1:0] depth_o
);
  import vic_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Preemption bits sit at the top of the implemented field
  function automatic logic [IMPL_W-1:0] pre_mask(input logic [2:0] grp);
    case (grp)
      3'h0: pre_mask = 3'b000;
      3'h1: pre_mask = 3'b100;
      3'h2: pre_mask = 3'b110;
      default: pre_mask = 3'b111;
    endcase
  endfunction

  // ==========================================================
  // Source synchroniser
  logic [NUM_SRC-1:0] src_s1_reg;
  logic [NUM_SRC-1:0] src_s2_reg;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      src_s1_reg <= '0;
      src_s2_reg <= '0;
    end else begin
      src_s1_reg <= irq_src_i;
      src_s2_reg <= src_s1_reg;
    end
  end

  // ==========================================================
  // Registers
  logic [NUM_SRC-1:0] en_reg;
  logic gmask_reg;
  logic [2:0] group_reg;
  logic [31:0] vbase_reg;
  logic [PRIO_W-1:0] prio_reg [NUM_SRC];
  logic [NUM_SRC-1:0] active_reg;
  logic [IDX_W-1:0] stk_idx_reg [DEPTH_MAX];
  logic [IMPL_W-1:0] stk_pri_reg [DEPTH_MAX];
  logic [DEPTH_W-1:0] depth_reg;
  logic irq_req_reg;
  logic [IDX_W-1:0] irq_num_reg;
  logic [IMPL_W-1:0] irq_pri_reg;
  logic [31:0] irq_addr_reg;
  logic in_irq_reg;
  vic_bus_st_t st_reg;
  logic wait_reg;
  logic [31:0] rdata_reg;

  // ==========================================================
  // Bus decode
  wire bus_req = avs_read_i || avs_write_i;
  wire wr_fire = (st_reg == BUS_DONE) && avs_write_i;
  wire prio_hit = (avs_address_i[9:7] == PRIO_PAGE);
  wire [IDX_W-1:0] prio_sel = avs_address_i[6:2];
  wire hit_enable = (avs_address_i == OFF_ENABLE);
  wire hit_en_set = (avs_address_i == OFF_EN_SET);
  wire hit_en_clr = (avs_address_i == OFF_EN_CLR);
  wire hit_gmask = (avs_address_i == OFF_GMASK);
  wire hit_group = (avs_address_i == OFF_GROUP);
  wire hit_vbase = (avs_address_i == OFF_VBASE);
  wire [31:0] wr_en_word = be_merge(32'h0000_0000, avs_writedata_i, avs_byteenable_i);
  wire [31:0] prio_word = be_merge({24'h00_0000, prio_reg[prio_sel]}, avs_writedata_i,
                                   avs_byteenable_i);
  wire [31:0] group_word = be_merge({29'h0, group_reg}, avs_writedata_i, avs_byteenable_i);
  wire [31:0] gmask_word = be_merge({31'h0, gmask_reg}, avs_writedata_i, avs_byteenable_i);

  // Grouping 3..7 all mean every implemented bit preempts
  wire [2:0] eff_group = (group_reg > GROUP_MAX) ? GROUP_MAX : group_reg;
  wire [IMPL_W-1:0] pmask = pre_mask(group_reg);

  // ==========================================================
  // Arbitration
  vic_arb_if arb_if ();
  wire [NUM_SRC-1:0] pend = src_s2_reg & en_reg;
  assign arb_if.cand = pend & ~active_reg;
  for (genvar g = 0; g < NUM_SRC; g++) begin : g_prio
    assign arb_if.prio[g] = prio_reg[g][PRIO_W-1 -: IMPL_W];
  end

  vic_arb u_arb (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .arb(arb_if)
  );

  wire [DEPTH_W-1:0] top_pos = depth_reg - 4'h1;
  wire [IMPL_W-1:0] run_pre = stk_pri_reg[top_pos[2:0]] & pmask;
  wire [IMPL_W-1:0] win_pre = arb_if.win_prio & pmask;
  // Equal preemption never beats the running handler; it waits for the end
  wire beats = (depth_reg == 4'h0) || (win_pre < run_pre);
  wire take = irq_ack_i && irq_req_reg && (depth_reg != 4'(DEPTH_MAX));
  wire finish = irq_eoi_i && (depth_reg != 4'h0) && !take;
  // Request is dropped for one cycle around ack and end so the stack settles
  wire req_next = arb_if.win_vld && beats && !gmask_reg && !irq_ack_i && !irq_eoi_i;
  // Not gated by ack or end, so context does not blink off during a tail chain
  wire waiting = arb_if.win_vld && !gmask_reg;
  wire [DEPTH_W-1:0] depth_next = take ? depth_reg + 4'h1 :
                                  finish ? depth_reg - 4'h1 : depth_reg;

  // ==========================================================
  // Nesting stack
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      depth_reg <= '0;
      active_reg <= '0;
      for (int k = 0; k < DEPTH_MAX; k++) begin
        stk_idx_reg[k] <= '0;
        stk_pri_reg[k] <= '0;
      end
    end else begin
      depth_reg <= depth_next;
      if (take) begin
        stk_idx_reg[depth_reg[2:0]] <= irq_num_reg;
        stk_pri_reg[depth_reg[2:0]] <= irq_pri_reg;
        active_reg[irq_num_reg] <= 1'b1;
      end else if (finish) begin
        active_reg[stk_idx_reg[top_pos[2:0]]] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Core request outputs
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_req_reg <= 1'b0;
      irq_num_reg <= '0;
      irq_pri_reg <= '0;
      irq_addr_reg <= '0;
      in_irq_reg <= 1'b0;
    end else begin
      irq_req_reg <= req_next;
      irq_num_reg <= arb_if.win_idx;
      irq_pri_reg <= arb_if.win_prio;
      irq_addr_reg <= vbase_reg + {25'h000_0000, arb_if.win_idx, 2'b00};
      // Tail chaining keeps context alive while a request is waiting
      in_irq_reg <= (depth_next != 4'h0) || waiting;
    end
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      en_reg <= RST_ENABLE;
      gmask_reg <= RST_GMASK;
      group_reg <= RST_GROUP;
      vbase_reg <= RST_VBASE;
      for (int k = 0; k < NUM_SRC; k++) begin
        prio_reg[k] <= RST_PRIO;
      end
    end else if (wr_fire) begin
      // Only this block's own enables change; sources keep their own masks
      if (hit_enable) begin
        en_reg <= be_merge(en_reg, avs_writedata_i, avs_byteenable_i);
      end
      if (hit_en_set) begin
        en_reg <= en_reg | wr_en_word;
      end
      if (hit_en_clr) begin
        en_reg <= en_reg & ~wr_en_word;
      end
      if (hit_gmask) begin
        gmask_reg <= gmask_word[GMASK_BIT];
      end
      if (hit_group) begin
        group_reg <= group_word[2:0];
      end
      if (hit_vbase) begin
        vbase_reg <= be_merge(vbase_reg, avs_writedata_i, avs_byteenable_i);
      end
      if (prio_hit) begin
        prio_reg[prio_sel] <= prio_word[PRIO_W-1:0];
      end
    end
  end

  // ==========================================================
  // Read mux; unmapped addresses read zero
  wire [31:0] status_word = {11'h000, irq_num_reg, 4'h0, depth_reg, 1'b0,
                             stk_pri_reg[top_pos[2:0]], 3'h0, in_irq_reg};
  wire [31:0] rd_mux =
    hit_enable ? en_reg :
    hit_en_set ? en_reg :
    hit_en_clr ? en_reg :
    hit_gmask ? {31'h0, gmask_reg} :
    hit_group ? {29'h0, eff_group} :
    (avs_address_i == OFF_PEND) ? pend :
    (avs_address_i == OFF_ACTIVE) ? active_reg :
    (avs_address_i == OFF_STATUS) ? status_word :
    hit_vbase ? vbase_reg :
    prio_hit ? {24'h00_0000, prio_reg[prio_sel]} :
    32'h0000_0000;

  // ==========================================================
  // Avalon slave: one wait cycle, then a one-cycle answer
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_reg <= BUS_IDLE;
      wait_reg <= 1'b1;
      rdata_reg <= '0;
    end else begin
      case (st_reg)
        BUS_IDLE: begin
          if (bus_req) begin
            st_reg <= BUS_DONE;
            wait_reg <= 1'b0;
            rdata_reg <= rd_mux;
          end
        end
        BUS_DONE: begin
          st_reg <= BUS_IDLE;
          wait_reg <= 1'b1;
        end
        default: begin
          st_reg <= BUS_IDLE;
          wait_reg <= 1'b1;
        end
      endcase
    end
  end

  assign avs_readdata_o = rdata_reg;
  assign avs_waitrequest_o = wait_reg;
  assign irq_req_o = irq_req_reg;
  assign irq_num_o = irq_num_reg;
  assign irq_addr_o = irq_addr_reg;
  assign in_irq_o = in_irq_reg;
  assign depth_o = depth_reg;

  // ==========================================================
  // Checks
  gmask_block_a: assert property (@(posedge clk_i) disable iff (srst_i)
    gmask_reg |=> !irq_req_reg) else $error("request passed the global mask");

  gmask_keep_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (wr_fire && hit_gmask) |=> en_reg == $past(en_reg))
    else $error("global mask write changed source enables");

  vec_addr_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (irq_req_reg && $stable(vbase_reg)) |->
      irq_addr_reg == vbase_reg + {25'h000_0000, irq_num_reg, 2'b00})
    else $error("handler address does not match the presented source");

  no_preempt_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (!beats && !(wr_fire && hit_group)) |=> !irq_req_reg)
    else $error("request raised without beating the running handler");

  en_gate_a: assert property (@(posedge clk_i) disable iff (srst_i)
    req_next |-> (en_reg[arb_if.win_idx] && src_s2_reg[arb_if.win_idx]))
    else $error("disabled or idle source forwarded");

  push_depth_a: assert property (@(posedge clk_i) disable iff (srst_i)
    take |=> (depth_reg == $past(depth_reg) + 4'h1) && !irq_req_reg && in_irq_reg)
    else $error("acceptance did not nest");

  pop_depth_a: assert property (@(posedge clk_i) disable iff (srst_i)
    finish |=> (depth_reg == $past(depth_reg) - 4'h1) && (active_reg != $past(active_reg)))
    else $error("handler end did not unwind");

  group_read_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (st_reg == BUS_IDLE && avs_read_i && hit_group) |=>
      rdata_reg == {29'h0, (($past(group_reg) > 3'h3) ? 3'h3 : $past(group_reg))})
    else $error("grouping read-back wrong");

  bus_ans_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (st_reg == BUS_IDLE && bus_req) |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer timing wrong");

  preempt_strict_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (irq_req_reg && depth_reg != 4'h0 && $stable(group_reg)) |->
      (irq_pri_reg & pmask) < run_pre)
    else $error("request shown without strictly better preemption");

  ctx_nested_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (depth_reg != 4'h0) |-> in_irq_reg) else $error("context left while handlers nested");

  ctx_chain_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (finish && depth_reg == 4'h1 && waiting) |=> in_irq_reg)
    else $error("context dropped while a source waits");

  depth_cap_a: assert property (@(posedge clk_i) disable iff (srst_i)
    depth_reg <= 4'(DEPTH_MAX)) else $error("nesting deeper than the stack");

  group_full_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (group_reg >= 3'h3) |-> pmask == 3'h7) else $error("grouping above three still splits");

  active_skip_a: assert property (@(posedge clk_i) disable iff (srst_i)
    irq_req_reg |-> !active_reg[irq_num_reg]) else $error("active handler requested again");

  en_clear_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (wr_fire && hit_en_clr) |=> (en_reg & $past(wr_en_word)) == '0)
    else $error("enable clear left a bit set");

endmodule

// file: tb/test_vectored_priority_irq_controller.sv
`timescale 1ns/1ns
module test_vectored_priority_irq_controller;
  import vic_pkg::*;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [ADDR_W-1:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [NUM_SRC-1:0] irq_src = 32'h0;
  logic [1:0] lag = 2'h0;
  logic eoi_go = 1'b0;
  logic [31:0] avs_readdata, irq_addr, took_addr;
  logic [31:0] vbase = 32'h0;
  logic [31:0] en = 32'h0;
  logic avs_waitrequest, irq_req, in_irq, irq_ack, irq_eoi, took;
  logic [IDX_W-1:0] irq_num, took_num;
  logic [DEPTH_W-1:0] depth;
  logic [31:0] rd_q[$];
  logic [36:0] ack_q[$];
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;

  vic_top dut (.clk_i(clk_i), .srst_i(srst_i), .avs_address_i(avs_address),
    .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
    .avs_byteenable_i(avs_byteenable), .avs_readdata_o(avs_readdata),
    .avs_waitrequest_o(avs_waitrequest), .irq_src_i(irq_src), .irq_ack_i(irq_ack),
    .irq_eoi_i(irq_eoi), .irq_req_o(irq_req), .irq_num_o(irq_num), .irq_addr_o(irq_addr),
    .in_irq_o(in_irq), .depth_o(depth));
  vic_core_model core (.clk_i(clk_i), .srst_i(srst_i), .irq_req_i(irq_req),
    .irq_num_i(irq_num), .irq_addr_i(irq_addr), .lag_i(lag), .eoi_go_i(eoi_go),
    .irq_ack_o(irq_ack), .irq_eoi_o(irq_eoi), .took_o(took), .took_num_o(took_num),
    .took_addr_o(took_addr));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  // ==========================================================
  // Verdict and compares
  task automatic finish_test();
    if (errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk_rd(input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED readdata exp %h got %h", e, g);
    end
  endtask
  task automatic chk_ack(input logic [36:0] e, input logic [36:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED handoff exp %h got %h", e, g);
    end
  endtask
  task automatic chk_lvl(input string n, input logic [3:0] e, input logic [3:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask

  // ==========================================================
  // Bus and core stimulus
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    @(posedge clk_i);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk_i); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, 32'h0, 4'hF);
  endtask
  task automatic prio(input logic [4:0] n, input logic [7:0] p);
    bus(1'b1, {PRIO_PAGE, n, 2'b00}, {24'h0, p}, 4'hF);
    rd({PRIO_PAGE, n, 2'b00}, {24'h0, p});
  endtask
  // Noise lands only on disabled sources, which must stay invisible
  task automatic set_src(input logic [31:0] s);
    @(posedge clk_i);
    irq_src <= s | ($urandom & ~en);
    lag <= 2'($urandom_range(3));
  endtask
  task automatic expect_ack(input logic [4:0] n);
    ack_q.push_back({n, vbase + {25'h0, n, 2'b00}});
  endtask
  task automatic wait_q(input int n);
    while (ack_q.size() > n) @(posedge clk_i);
    repeat (2) @(posedge clk_i);
  endtask
  // Sources are lowered first; the sync delay must pass before the eoi
  task automatic end_isr();
    repeat (3) @(posedge clk_i);
    eoi_go <= 1'b1;
    @(posedge clk_i);
    eoi_go <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  // ==========================================================
  // Monitor and timeout
  always @(posedge clk_i) begin
    cycles++;
    if (avs_read && avs_waitrequest === 1'b0) begin
      chk_rd(rd_q.size() > 0 ? rd_q.pop_front() : 32'hBAD0_0BAD, avs_readdata);
    end
    if (took) begin
      chk_ack(ack_q.size() > 0 ? ack_q.pop_front() : '1, {took_num, took_addr});
    end
    if (cycles == 20000) begin
      errors++;
      $display("CHECK FAILED run_length exp done got hang");
      finish_test();
    end
  end

  // ==========================================================
  // Scenarios
  initial begin
    void'($urandom(96));
    repeat (20) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    rd(OFF_ENABLE, RST_ENABLE);
    rd(OFF_GMASK, 32'h0);
    rd(OFF_VBASE, RST_VBASE);
    rd(OFF_GROUP, 32'h3);
    rd(10'h3FC, 32'h0);
    for (int g = 7; g >= 0; g--) begin
      bus(1'b1, OFF_GROUP, 32'(g), 4'hF);
      rd(OFF_GROUP, (g > 3) ? 32'h3 : 32'(g));
    end
    vbase = $urandom & 32'hFFFF_FF00;
    bus(1'b1, OFF_VBASE, vbase, 4'hF);
    rd(OFF_VBASE, vbase);
    bus(1'b1, OFF_GMASK, 32'h1, 4'hF);
    en = $urandom;
    bus(1'b1, OFF_EN_SET, en, 4'hF);
    set_src(32'hFFFF_FFFF);
    repeat (8) @(posedge clk_i);
    chk_lvl("irq_req", 4'h0, {3'h0, irq_req});
    set_src(32'h0);
    repeat (4) @(posedge clk_i);
    bus(1'b1, OFF_GMASK, 32'h0, 4'hF);
    rd(OFF_ENABLE, en);
    bus(1'b1, OFF_EN_CLR, 32'hFFFF_FFFF, 4'h1);
    en = en & 32'hFFFF_FF00;
    rd(OFF_ENABLE, en);
    bus(1'b1, OFF_ENABLE, 32'h0, 4'h2);
    en = en & 32'hFFFF_00FF;
    rd(OFF_ENABLE, en);
    bus(1'b1, OFF_EN_CLR, 32'hFFFF_FFFF, 4'hF);
    en = 32'h0000_FFFF;
    set_src(32'h0);
    bus(1'b1, OFF_EN_SET, en, 4'hF);
    rd(OFF_EN_SET, en);
    // Grouping 5 must act as 3: every implemented bit preempts
    bus(1'b1, OFF_GROUP, 32'h5, 4'hF);
    prio(5'h05, 8'h9F);
    prio(5'h09, 8'h80);
    expect_ack(5'h05);
    expect_ack(5'h09);
    set_src(32'h220);
    wait_q(1);
    repeat (8) @(posedge clk_i);
    chk_lvl("queued", 4'h1, 4'(ack_q.size()));
    chk_lvl("depth", 4'h1, depth);
    set_src(32'h200);
    end_isr();
    wait_q(0);
    chk_lvl("in_irq", 4'h1, {3'h0, in_irq});
    set_src(32'h0);
    end_isr();
    prio(5'h03, 8'hA0);
    prio(5'h0C, 8'h20);
    prio(5'h07, 8'h00);
    expect_ack(5'h03);
    set_src(32'h8);
    wait_q(0);
    expect_ack(5'h0C);
    set_src(32'h1008);
    wait_q(0);
    expect_ack(5'h07);
    set_src(32'h1088);
    wait_q(0);
    chk_lvl("depth", 4'h3, depth);
    set_src(32'h0);
    repeat (3) end_isr();
    chk_lvl("depth", 4'h0, depth);
    chk_lvl("in_irq", 4'h0, {3'h0, in_irq});
    // One preemption bit: bit 7 alone decides preemption
    bus(1'b1, OFF_GROUP, 32'h1, 4'hF);
    prio(5'h02, 8'hC0);
    prio(5'h06, 8'h80);
    prio(5'h0E, 8'h60);
    expect_ack(5'h02);
    set_src(32'h4);
    wait_q(0);
    expect_ack(5'h0E);
    expect_ack(5'h06);
    set_src(32'h4044);
    wait_q(1);
    chk_lvl("depth", 4'h2, depth);
    set_src(32'h44);
    end_isr();
    repeat (8) @(posedge clk_i);
    chk_lvl("queued", 4'h1, 4'(ack_q.size()));
    set_src(32'h40);
    end_isr();
    wait_q(0);
    set_src(32'h0);
    end_isr();
    chk_lvl("depth", 4'h0, depth);
    finish_test();
  end
endmodule

// file: tb/vic_core_model.sv
`timescale 1ns/1ns
// ==========================================================
// Core side: takes requests after a chosen lag, ends handlers
module vic_core_model (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic irq_req_i,
  input wire logic [4:0] irq_num_i,
  input wire logic [31:0] irq_addr_i,
  input wire logic [1:0] lag_i,
  input wire logic eoi_go_i,
  output logic irq_ack_o = 1'b0,
  output logic irq_eoi_o = 1'b0,
  output logic took_o = 1'b0,
  output logic [4:0] took_num_o,
  output logic [31:0] took_addr_o
);
  logic eoi_pend_reg = 1'b0;
  logic [1:0] wait_reg = 2'h0;
  // End of handler wins, so ack and eoi never share a cycle
  always @(posedge clk_i) begin
    irq_ack_o <= 1'b0;
    irq_eoi_o <= 1'b0;
    took_o <= irq_ack_o && irq_req_i;
    took_num_o <= irq_num_i;
    took_addr_o <= irq_addr_i;
    if (srst_i) begin
      eoi_pend_reg <= 1'b0;
      wait_reg <= 2'h0;
    end else if ((eoi_pend_reg || eoi_go_i) && !irq_ack_o) begin
      irq_eoi_o <= 1'b1;
      eoi_pend_reg <= 1'b0;
    end else begin
      eoi_pend_reg <= eoi_pend_reg || eoi_go_i;
      wait_reg <= irq_req_i ? wait_reg + 2'h1 : 2'h0;
      // Ack only while a request is shown
      if (irq_req_i && !irq_ack_o && wait_reg >= lag_i) begin
        irq_ack_o <= 1'b1;
        wait_reg <= 2'h0;
      end
    end
  end
endmodule
